/* rtl/sync_cfg_pkg.sv */
// Constants, types and tables for the switching frequency and sync block
package sync_cfg_pkg;

  // Clock and frequency figures in kHz
  localparam logic [15:0] CLK_FREQ_KHZ = 16'h61a8;  // 25000 kHz
  localparam logic [15:0] STEP_KHZ     = 16'h0032;  // 50 kHz
  localparam logic [15:0] MIN_FREQ_KHZ = 16'h012c;  // 300 kHz
  localparam logic [15:0] MAX_FREQ_KHZ = 16'h05dc;  // 1500 kHz

  // Counts in clock cycles derived from the figures above
  localparam logic [7:0] PER_MAX_CYC      = 8'(CLK_FREQ_KHZ / MIN_FREQ_KHZ);
  localparam logic [7:0] PER_MIN_CYC      = 8'(CLK_FREQ_KHZ / MAX_FREQ_KHZ);
  localparam logic [7:0] SYNC_TIMEOUT_CYC = 8'((32'(CLK_FREQ_KHZ) * 2) / 32'(MIN_FREQ_KHZ));

  // Legal programmed range in 50 kHz steps
  localparam logic [4:0] STEP_MIN = 5'(MIN_FREQ_KHZ / STEP_KHZ);
  localparam logic [4:0] STEP_MAX = 5'(MAX_FREQ_KHZ / STEP_KHZ);

  // Resistor index to frequency, in 50 kHz steps
  localparam int RT_CODES = 15;
  localparam logic [4:0] RT_STEP_TABLE [RT_CODES] = '{
    5'h06, 5'h08, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f,
    5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h19, 5'h1e
  };

  // Phase-mode command values
  localparam logic [15:0] PM_STANDALONE = 16'h0000;
  localparam logic [15:0] PM_MASTER     = 16'h0100;
  localparam logic [15:0] PM_SLAVE_IN   = 16'h0120;
  localparam logic [15:0] PM_SLAVE_ANTI = 16'h0121;

  typedef enum logic [1:0] {
    MODE_STANDALONE = 2'b00,
    MODE_MASTER     = 2'b01,
    MODE_SLAVE_IN   = 2'b10,
    MODE_SLAVE_ANTI = 2'b11
  } sync_mode_t;

  localparam sync_mode_t MODE_RESET = MODE_MASTER;

  // Management-bus write strobe with its data word
  typedef struct packed {
    logic        wr;
    logic [15:0] data;
  } cmd_t;

  // Observable state of the block
  typedef struct packed {
    sync_mode_t mode;
    logic       ext_lock;
    logic       init_done;
    logic [4:0] freq_step;
    logic [7:0] period;
  } sync_status_t;

endpackage

/* rtl/phase_clock.sv */
// Switching-phase counter producing a 50 % duty square wave
module phase_clock
  import sync_cfg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] period,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  output logic      [7:0] count,
  output logic            sw_high
);

  logic [7:0] count_q;
  logic [7:0] count_d;
  logic       sw_q;
  wire  [7:0] half = {1'b0, period[7:1]};
  wire        wrap = (count_q >= period - 8'h01);

  // Loading realigns phase at once; a wrap starts a new switching cycle
  assign count_d = load ? load_val : (wrap ? 8'h00 : count_q + 8'h01);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count_q <= 8'h00;
      sw_q    <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      sw_q    <= (count_d < half);
    end
  end

  assign count   = count_q;
  assign sw_high = sw_q;

endmodule

/* rtl/switching_sync_config.sv */
// Switching frequency selection and sync pin master/slave control
// Function
// - At power up, map resistor index to one of fifteen frequencies, 300 to 1500 kHz.
// - A management write may replace the resistor frequency, in 50 kHz steps.
// - Four configurations exist; master after reset; phase-mode write switches configuration.
// - Phase-mode values: 0x0000 standalone, 0x0100 master, 0x0120/0x0121 slave in/anti.
// - Standalone after power up: sync pin not driven, no sync output.
// - Master after power up: drive 50 % square wave in phase with switching.
// - Slave in phase with external clock: take its frequency, align phase to it.
// - Slave antiphase with external clock: take its frequency, offset half a period.
module switching_sync_config
  import sync_cfg_pkg::*;
(
  input  wire logic         CLK,
  input  wire logic         SYS_RST,
  input  wire logic         INIT_DONE,
  input  wire logic [3:0]   FREQ_SET_RESISTOR,
  input  wire cmd_t         FREQ_CMD,
  input  wire cmd_t         PHASE_MODE_COMMAND,
  input  wire logic         FREQ_SET_SYNC_PIN_IN,
  output logic              FREQ_SET_SYNC_PIN_OUT,
  output logic              FREQ_SET_SYNC_PIN_OE,
  output logic              SW_NODE,
  output sync_status_t      STATUS
);

  // Cycles per switching period for a frequency given in 50 kHz steps.
  // Restoring division keeps this constant-time without a divide operator.
  function automatic logic [7:0] cycles_per_period(input logic [4:0] step);
    logic [15:0] den;
    logic [16:0] rem;
    logic [15:0] quo;
    den = 16'(step) * STEP_KHZ;
    rem = 17'h00000;
    quo = 16'h0000;
    for (int i = 15; i >= 0; i--)
    begin
      rem = {rem[15:0], CLK_FREQ_KHZ[i]};
      if (rem >= {1'b0, den})
      begin
        rem    = rem - {1'b0, den};
        quo[i] = 1'b1;
      end
    end
    return quo[7:0];
  endfunction

  // State
  logic       init_done_q;
  logic [4:0] step_q;
  logic [4:0] step_d;
  sync_mode_t mode_q;
  sync_mode_t mode_d;
  logic       pin_prev_q;
  logic [7:0] gap_q;
  logic [7:0] gap_d;
  logic [7:0] meas_q;
  logic [7:0] meas_d;
  logic       lock_q;
  logic       lock_d;
  logic       oe_q;

  // Resistor lookup; an out-of-table index falls back to the lowest setting
  wire        rt_in_table = (FREQ_SET_RESISTOR < 4'(RT_CODES));
  wire  [4:0] rt_step     = rt_in_table ? RT_STEP_TABLE[FREQ_SET_RESISTOR]
                                        : RT_STEP_TABLE[0];

  // Programmed frequency is taken only when on the step grid and in range
  wire        freq_ok  = (FREQ_CMD.data[15:5] == 11'h000)
                       && (FREQ_CMD.data[4:0] >= STEP_MIN)
                       && (FREQ_CMD.data[4:0] <= STEP_MAX);
  wire        freq_wr  = FREQ_CMD.wr && init_done_q && freq_ok;

  // Resistor is sensed only while power-up init runs, then frozen
  assign step_d = !init_done_q ? rt_step
                : freq_wr      ? FREQ_CMD.data[4:0]
                :                step_q;

  // Phase-mode decode; unknown values leave the configuration as it was
  wire pm_wr = PHASE_MODE_COMMAND.wr;

  always_comb
  begin
    mode_d = mode_q;
    if (pm_wr)
    begin
      case (PHASE_MODE_COMMAND.data)
        PM_STANDALONE: mode_d = MODE_STANDALONE;
        PM_MASTER:     mode_d = MODE_MASTER;
        PM_SLAVE_IN:   mode_d = MODE_SLAVE_IN;
        PM_SLAVE_ANTI: mode_d = MODE_SLAVE_ANTI;
        default:       mode_d = mode_q;
      endcase
    end
  end

  // External clock detection, only meaningful in the slave modes
  wire is_slave   = (mode_q == MODE_SLAVE_IN) || (mode_q == MODE_SLAVE_ANTI);
  // Own drive lingers a cycle after leaving master; it is no external edge
  wire pin_rise   = is_slave && init_done_q && !oe_q
                    && FREQ_SET_SYNC_PIN_IN && !pin_prev_q;
  wire [7:0] gap1 = (gap_q == 8'hff) ? gap_q : gap_q + 8'h01;
  wire gap_legal  = (gap1 >= PER_MIN_CYC) && (gap1 <= PER_MAX_CYC);
  wire timed_out  = (gap_q >= SYNC_TIMEOUT_CYC);

  // Parked saturated outside slave, so the first edge after entry cannot lock
  assign gap_d  = !is_slave ? 8'hff
                : pin_rise  ? 8'h00
                :             gap1;
  assign meas_d = (pin_rise && gap_legal) ? gap1 : meas_q;

  // Lock needs two edges a legal period apart; a missing edge drops it
  assign lock_d = !is_slave          ? 1'b0
                : pin_rise           ? gap_legal
                : timed_out          ? 1'b0
                :                      lock_q;

  // Period source: measured external clock when locked, else own setting
  wire [7:0] own_period = cycles_per_period(step_q);
  wire [7:0] period     = lock_q ? meas_q : own_period;

  // Edge realigns the phase counter; antiphase lands half a period away.
  // Realignment waits for lock so a stray first edge does not jolt phase.
  wire       align      = pin_rise && lock_q && gap_legal;
  wire [7:0] align_val  = (mode_q == MODE_SLAVE_ANTI) ? {1'b0, gap1[7:1]}
                                                      : 8'h00;

  // Pin driven only by a master after power up; the resistor owns it before
  wire oe_d = init_done_q && (mode_q == MODE_MASTER);

  // Power-up completion is sticky until the next reset
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      init_done_q <= 1'b0;
    else
      init_done_q <= init_done_q || INIT_DONE;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      step_q <= STEP_MIN;
    else
      step_q <= step_d;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      mode_q <= MODE_RESET;
    else
      mode_q <= mode_d;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      pin_prev_q <= 1'b0;
    else
      pin_prev_q <= FREQ_SET_SYNC_PIN_IN;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      gap_q <= 8'hff;
    else
      gap_q <= gap_d;
  end

  // Measured period starts at the slowest legal clock
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      meas_q <= PER_MAX_CYC;
    else
      meas_q <= meas_d;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      lock_q <= 1'b0;
    else
      lock_q <= lock_d;
  end

  // Enable from a flop so a mode write cannot glitch the pin drive
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      oe_q <= 1'b0;
    else
      oe_q <= oe_d;
  end

  logic       sw_high;

  phase_clock phase_clock_i (
    .clk      (CLK),
    .rst      (SYS_RST),
    .period   (period),
    .load     (align),
    .load_val (align_val),
    .count    (),
    .sw_high  (sw_high)
  );

  // Sync out is the switching flop itself, so its rising edge matches the node
  assign SW_NODE               = sw_high;
  assign FREQ_SET_SYNC_PIN_OUT = oe_q && sw_high;
  assign FREQ_SET_SYNC_PIN_OE  = oe_q;

  // Period reported is the one in use, measured or own
  assign STATUS.mode      = mode_q;
  assign STATUS.ext_lock  = lock_q;
  assign STATUS.init_done = init_done_q;
  assign STATUS.freq_step = step_q;
  assign STATUS.period    = period;

endmodule

/* dv/switching_sync_config_monitor.sv */
// Port checks for the switching frequency and sync block
module switching_sync_config_monitor
  import sync_cfg_pkg::*;
(
  input wire logic         CLK,
  input wire logic         SYS_RST,
  input wire cmd_t         FREQ_CMD,
  input wire cmd_t         PHASE_MODE_COMMAND,
  input wire logic         FREQ_SET_SYNC_PIN_OUT,
  input wire logic         FREQ_SET_SYNC_PIN_OE,
  input wire logic         SW_NODE,
  input wire sync_status_t STATUS
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_to_master;
    PHASE_MODE_COMMAND.wr && PHASE_MODE_COMMAND.data == PM_MASTER && STATUS.init_done;
  endsequence
  property p_master_oe;
    s_to_master ##1 !PHASE_MODE_COMMAND.wr |=> FREQ_SET_SYNC_PIN_OE;
  endproperty
  a_master_oe: assert property (p_master_oe) else $error("no drive after master");
  property p_oe_cause;
    FREQ_SET_SYNC_PIN_OE |-> $past(STATUS.mode) == MODE_MASTER;
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive outside master");
  property p_drive;
    FREQ_SET_SYNC_PIN_OE |-> FREQ_SET_SYNC_PIN_OUT == SW_NODE;
  endproperty
  a_drive: assert property (p_drive) else $error("sync out not switching");
  property p_quiet;
    !FREQ_SET_SYNC_PIN_OE |-> !FREQ_SET_SYNC_PIN_OUT;
  endproperty
  a_quiet: assert property (p_quiet) else $error("sync out while released");
  property p_mode_sa;
    PHASE_MODE_COMMAND.wr && PHASE_MODE_COMMAND.data == PM_STANDALONE
      |=> STATUS.mode == MODE_STANDALONE;
  endproperty
  a_mode_sa: assert property (p_mode_sa) else $error("standalone not taken");
  property p_mode_anti;
    PHASE_MODE_COMMAND.wr && PHASE_MODE_COMMAND.data == PM_SLAVE_ANTI
      |=> STATUS.mode == MODE_SLAVE_ANTI;
  endproperty
  a_mode_anti: assert property (p_mode_anti) else $error("antiphase not taken");
  property p_freq;
    FREQ_CMD.wr && STATUS.init_done && FREQ_CMD.data inside {[6:30]}
      |=> STATUS.freq_step == $past(FREQ_CMD.data[4:0]);
  endproperty
  a_freq: assert property (p_freq) else $error("frequency write lost");
  property p_step_hold;
    STATUS.init_done && !FREQ_CMD.wr |=> $stable(STATUS.freq_step);
  endproperty
  a_step_hold: assert property (p_step_hold) else $error("step moved alone");
  property p_period;
    !STATUS.ext_lock |-> STATUS.period == 8'(16'd500 / STATUS.freq_step);
  endproperty
  a_period: assert property (p_period) else $error("own period wrong");
  property p_lock_slave;
    $rose(STATUS.ext_lock) |-> $past(STATUS.mode[1]);
  endproperty
  a_lock_slave: assert property (p_lock_slave) else $error("lock outside slave");
endmodule

bind switching_sync_config switching_sync_config_monitor switching_sync_config_monitor_i (
  .CLK(CLK), .SYS_RST(SYS_RST), .FREQ_CMD(FREQ_CMD), .PHASE_MODE_COMMAND(PHASE_MODE_COMMAND),
  .FREQ_SET_SYNC_PIN_OUT(FREQ_SET_SYNC_PIN_OUT), .FREQ_SET_SYNC_PIN_OE(FREQ_SET_SYNC_PIN_OE),
  .SW_NODE(SW_NODE), .STATUS(STATUS));

/* dv/sync_peer.sv */
// Far-side converter that drives a sync clock onto the shared pin
module sync_peer
(
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [7:0] gap,
  output logic            sync
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q = '0;
  // Stopped clock stays low: sync is driven to 0 whenever run is low
  always @(posedge clk)
  begin
    cnt_q <= (run && cnt_q + 8'h01 < gap) ? cnt_q + 8'h01 : 8'h00;
    sync  <= run && cnt_q < gap / 2;
  end
endmodule

/* dv/switching_sync_config_bench.sv */
// Self-checking bench for the switching frequency and sync block
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("mismatch %s exp %0h got %0h", nm, e, a); end end
module switching_sync_config_bench
  import sync_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 0, rst = 1, init = 0, run = 0, out, oe, sw, psync, pin;
  logic [3:0]   rt_idx = '0;
  cmd_t         fcmd = '0, pcmd = '0;
  sync_status_t st;
  int           fails = 0, n_checks = 0, m;
  assign pin = oe ? out : psync;
  switching_sync_config switching_sync_config_i (.CLK(clk), .SYS_RST(rst), .INIT_DONE(init),
    .FREQ_SET_RESISTOR(rt_idx), .FREQ_CMD(fcmd), .PHASE_MODE_COMMAND(pcmd),
    .FREQ_SET_SYNC_PIN_IN(pin), .FREQ_SET_SYNC_PIN_OUT(out), .FREQ_SET_SYNC_PIN_OE(oe),
    .SW_NODE(sw), .STATUS(st));
  // Peer master shares our resistor, so it runs at 1500 kHz
  sync_peer sync_peer_i (.clk(clk), .run(run), .gap(8'h10), .sync(psync));
  initial forever #20 clk = ~clk;
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(bit f, logic [15:0] d);
    if (f) fcmd = '{1'b1, d}; else pcmd = '{1'b1, d};
    cyc(1);
    fcmd.wr = 0;
    pcmd.wr = 0;
    // Strobe seen low for an edge before any next write
    cyc(1);
  endtask
  task automatic phase(bit same);
    m = 0;
    repeat (40)
    begin
      cyc(1);
      m += (sw == psync);
    end
    `CHK("phase", 1'b1, same ? m > 30 : m < 10)
  endtask
  task automatic t_init;
    cyc(2);
    `CHK("step lo", 5'h06, st.freq_step)
    `CHK("oe pre", 1'b0, oe)
    `CHK("mode", MODE_MASTER, st.mode)
    rt_idx = 4'he; // Same resistor as the peer master
    cyc(2);
    `CHK("step hi", 5'h1e, st.freq_step)
    wr(1, 16'h0014);
    `CHK("early", 5'h1e, st.freq_step)
    init = 1;
    cyc(3);
    `CHK("oe", 1'b1, oe)
    `CHK("init", 1'b1, st.init_done)
    `CHK("period", 8'h10, st.period)
    m = 0;
    repeat (16)
    begin
      cyc(1);
      m += pin;
    end
    `CHK("duty", 8, m)
  endtask
  task automatic t_freq;
    wr(1, 16'h0014);
    `CHK("p20", 8'h19, st.period)
    wr(1, 16'h001f);
    `CHK("bad", 5'h14, st.freq_step)
    wr(1, 16'h0006);
    `CHK("p6", 8'h53, st.period)
  endtask
  task automatic t_modes;
    logic [15:0] v[5] = '{PM_STANDALONE, PM_SLAVE_IN, 16'h0122, PM_SLAVE_ANTI, PM_MASTER};
    sync_mode_t  e[5] = '{MODE_STANDALONE, MODE_SLAVE_IN, MODE_SLAVE_IN, MODE_SLAVE_ANTI,
                          MODE_MASTER};
    for (int i = 0; i < 5; i++)
    begin
      wr(0, v[i]);
      `CHK("mode", e[i], st.mode)
      cyc(1);
      `CHK("oe", e[i] == MODE_MASTER, oe)
    end
  endtask
  task automatic t_slave;
    wr(0, PM_SLAVE_IN);
    run = 1;
    cyc(100);
    `CHK("lock", 1'b1, st.ext_lock)
    `CHK("gap", 8'h10, st.period)
    phase(1);
    wr(0, PM_SLAVE_ANTI);
    cyc(100);
    phase(0);
    run = 0;
    cyc(200);
    `CHK("unlock", 1'b0, st.ext_lock)
    `CHK("own", 8'h53, st.period)
  endtask
  task automatic complete_run;
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(3);
    rst = 0;
    t_init();
    t_freq();
    t_modes();
    t_slave();
    complete_run();
  end
  initial
  begin
    #100000;
    fails++;
    complete_run();
  end
endmodule
